// ---- vcs_cal_ctrl.sv ----
// host controller: factory vco sweep with record capture, in-field recall
`timescale 1ns/1ps
module vcs_cal_ctrl
	import vcs_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic [4:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic [31:0]       reg_rdata,
	output logic              ser_clk,
	output logic              ser_csn,
	output logic              ser_mosi,
	input  wire logic         lock_detect_out_pin
);
	logic                     rst_m_q;
	logic                     rst_n_q;
	vcs_state_t               state_q;
	logic                     issued_q;
	logic                     start_q;
	logic [FRAME_W-1:0]       word_q;
	logic [FREQ_W-1:0]        start_khz_q, stop_khz_q, step_khz_q, pfd_khz_q;
	logic [FREQ_W-1:0]        target_khz_q, cur_khz_q;
	logic [N_W-1:0]           start_n_q, target_n_q, cur_n_q;
	logic [FRAC_W-1:0]        start_frac_q, target_frac_q, cur_frac_q;
	logic [WAIT_W-1:0]        lock_wait_q, wait_q;
	logic [DEV_DATA_W-1:0]    div_tmpl_q, frac_tmpl_q, cal_tmpl_q;
	logic [DEV_DATA_W-1:0]    stat_q;
	logic [REC_W-1:0]         rec_q [REC_DEPTH];
	logic [REC_CNT_W-1:0]     rec_cnt_q, scan_q;
	logic [REC_IDX_W-1:0]     rec_idx_q, hit_q;
	logic                     found_q, first_q;
	logic [PAIR_W-1:0]        prev_pair_q;
	logic                     sweep_done_q, recall_done_q;
	logic                     lock_err_q, full_err_q, no_match_q;

	vcs_ser_if ser ();

	vcs_ser_shift u_shift (
		.clk      (ref_clk),
		.rst_n    (rst_n_q),
		.req      (ser.shift),
		.ser_clk  (ser_clk),
		.ser_csn  (ser_csn),
		.ser_mosi (ser_mosi),
		.ser_miso (lock_detect_out_pin)
	);

	assign ser.start = start_q;
	assign ser.word  = word_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// register port decode
	wire idle      = state_q == ST_IDLE;
	wire wr_ctrl   = reg_wr && reg_addr == OFF_CTRL;
	wire sweep_go  = idle && wr_ctrl && reg_wdata[CTRL_SWEEP];
	wire recall_go = idle && wr_ctrl && !reg_wdata[CTRL_SWEEP]
	                 && reg_wdata[CTRL_RECALL];
	wire clear_go  = idle && wr_ctrl && reg_wdata[CTRL_CLEAR];
	wire wr_cnt    = idle && reg_wr && reg_addr == OFF_REC_COUNT;
	wire rec_acc   = (reg_wr || reg_rd) && reg_addr == OFF_REC_DATA;
	wire rec_bus_w = idle && reg_wr && reg_addr == OFF_REC_DATA;
	wire [FREQ_W-1:0] step_in = reg_wdata[FREQ_W-1:0];
	wire [FREQ_W-1:0] step_lim =
		step_in > STEP_MAX_KHZ ? STEP_MAX_KHZ :
		step_in < STEP_MIN_KHZ ? STEP_MIN_KHZ : step_in;
	wire [REC_CNT_W-1:0] cnt_in =
		reg_wdata[REC_CNT_W-1:0] > REC_CNT_W'(REC_DEPTH) ?
		REC_CNT_W'(REC_DEPTH) : reg_wdata[REC_CNT_W-1:0];

	// status register fields of the synthesizer
	wire              dev_lock = stat_q[DEV_LOCK_BIT];
	wire [PAIR_W-1:0] dev_pair = {stat_q[DEV_CORE_LSB +: CORE_W],
	                              stat_q[DEV_SUB_LSB +: SUB_W]};

	// next sweep point, the last one clipped onto the stop frequency
	wire [FREQ_W-1:0] to_stop = stop_khz_q - cur_khz_q;
	wire [FREQ_W-1:0] delta   =
		to_stop < step_khz_q ? to_stop : step_khz_q;
	wire [FREQ_W:0]   frac_sum = (FREQ_W+1)'(cur_frac_q)
	                             + (FREQ_W+1)'(delta);
	wire              frac_wrap = frac_sum >= (FREQ_W+1)'(pfd_khz_q);
	wire [FREQ_W:0]   frac_red =
		frac_wrap ? frac_sum - (FREQ_W+1)'(pfd_khz_q) : frac_sum;
	wire              at_stop   = cur_khz_q >= stop_khz_q;
	wire              new_pair  = first_q || dev_pair != prev_pair_q;
	wire              rec_full  = rec_cnt_q == REC_CNT_W'(REC_DEPTH);

	// record lookup
	wire [REC_W-1:0]  scan_rec  = rec_q[scan_q[REC_IDX_W-1:0]];
	wire              scan_ok   = scan_q < rec_cnt_q
	                              && scan_rec[FREQ_W-1:0] <= target_khz_q;
	wire [REC_W-1:0]  hit_rec   = rec_q[hit_q];

	// frame assembly per state; templates must hold zero in merged fields
	wire [DEV_DATA_W-1:0] frac_fld = DEV_DATA_W'(cur_frac_q);
	wire [DEV_DATA_W-1:0] n_fld    = DEV_DATA_W'(cur_n_q);
	wire [DEV_DATA_W-1:0] mfrac_fld = DEV_DATA_W'(target_frac_q)
		| (DEV_DATA_W'(1) << MAN_CAL_BIT);
	wire [DEV_DATA_W-1:0] mn_fld   = DEV_DATA_W'(target_n_q);
	wire [DEV_DATA_W-1:0] cal_fld  =
		(DEV_DATA_W'(hit_rec[FREQ_W+SUB_W +: CORE_W]) << CAL_CORE_LSB)
		| (DEV_DATA_W'(hit_rec[FREQ_W +: SUB_W]) << CAL_SUB_LSB);
	wire [FRAME_W-1:0] frame =
		state_q == ST_WR_FRAC  ? {FRAME_WR, DEV_FRAC_ADDR,
		                          frac_tmpl_q | frac_fld} :
		state_q == ST_WR_DIV   ? {FRAME_WR, DEV_DIV_ADDR,
		                          div_tmpl_q | n_fld} :
		state_q == ST_WR_CAL   ? {FRAME_WR, DEV_CAL_ADDR,
		                          cal_tmpl_q | cal_fld} :
		state_q == ST_WR_MFRAC ? {FRAME_WR, DEV_FRAC_ADDR,
		                          frac_tmpl_q | mfrac_fld} :
		state_q == ST_WR_MDIV  ? {FRAME_WR, DEV_DIV_ADDR,
		                          div_tmpl_q | mn_fld} :
		{FRAME_RD, DEV_STAT_ADDR, {DEV_DATA_W{1'b0}}};
	wire ser_state = state_q == ST_WR_FRAC || state_q == ST_WR_DIV
	                 || state_q == ST_RD_STAT || state_q == ST_WR_CAL
	                 || state_q == ST_WR_MFRAC || state_q == ST_WR_MDIV;

	// software-written configuration
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			start_khz_q   <= '0;
			stop_khz_q    <= '0;
			step_khz_q    <= STEP_MAX_KHZ;
			pfd_khz_q     <= '0;
			start_n_q     <= '0;
			start_frac_q  <= '0;
			target_khz_q  <= '0;
			target_n_q    <= '0;
			target_frac_q <= '0;
			lock_wait_q   <= WAIT_W'(LOCK_CYC);
			div_tmpl_q    <= '0;
			frac_tmpl_q   <= '0;
			cal_tmpl_q    <= '0;
		end else if (reg_wr && idle) begin
			if (reg_addr == OFF_START_KHZ)
				start_khz_q <= reg_wdata[FREQ_W-1:0];
			else if (reg_addr == OFF_STOP_KHZ)
				stop_khz_q <= reg_wdata[FREQ_W-1:0];
			else if (reg_addr == OFF_STEP_KHZ)
				step_khz_q <= step_lim;
			else if (reg_addr == OFF_PFD_KHZ)
				pfd_khz_q <= reg_wdata[FREQ_W-1:0];
			else if (reg_addr == OFF_START_N)
				start_n_q <= reg_wdata[N_W-1:0];
			else if (reg_addr == OFF_START_FRAC)
				start_frac_q <= reg_wdata[FRAC_W-1:0];
			else if (reg_addr == OFF_TARGET_KHZ)
				target_khz_q <= reg_wdata[FREQ_W-1:0];
			else if (reg_addr == OFF_TARGET_N)
				target_n_q <= reg_wdata[N_W-1:0];
			else if (reg_addr == OFF_TARGET_FRAC)
				target_frac_q <= reg_wdata[FRAC_W-1:0];
			else if (reg_addr == OFF_LOCK_WAIT)
				lock_wait_q <= reg_wdata[WAIT_W-1:0];
			else if (reg_addr == OFF_DIV_TMPL)
				div_tmpl_q <= reg_wdata[DEV_DATA_W-1:0];
			else if (reg_addr == OFF_FRAC_TMPL)
				frac_tmpl_q <= reg_wdata[DEV_DATA_W-1:0];
			else if (reg_addr == OFF_CAL_TMPL)
				cal_tmpl_q <= reg_wdata[DEV_DATA_W-1:0];
		end
	end

	// record store: filled by the sweep or loaded back from nonvolatile copy
	always_ff @(posedge ref_clk) begin
		if (state_q == ST_EVAL && dev_lock && new_pair && !rec_full)
			rec_q[rec_cnt_q[REC_IDX_W-1:0]] <= {dev_pair, cur_khz_q};
		else if (rec_bus_w)
			rec_q[rec_idx_q] <= reg_wdata[REC_W-1:0];
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			rec_idx_q <= '0;
		else if (reg_wr && reg_addr == OFF_REC_INDEX)
			rec_idx_q <= reg_wdata[REC_IDX_W-1:0];
		else if (rec_acc)
			rec_idx_q <= rec_idx_q + REC_IDX_W'(1);
	end

	// sequencer
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q       <= ST_IDLE;
			issued_q      <= 1'b0;
			start_q       <= 1'b0;
			word_q        <= '0;
			cur_khz_q     <= '0;
			cur_n_q       <= '0;
			cur_frac_q    <= '0;
			wait_q        <= '0;
			stat_q        <= '0;
			rec_cnt_q     <= '0;
			scan_q        <= '0;
			hit_q         <= '0;
			found_q       <= 1'b0;
			first_q       <= 1'b0;
			prev_pair_q   <= '0;
			sweep_done_q  <= 1'b0;
			recall_done_q <= 1'b0;
			lock_err_q    <= 1'b0;
			full_err_q    <= 1'b0;
			no_match_q    <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (ser_state && !issued_q && !ser.busy) begin
				start_q  <= 1'b1;
				word_q   <= frame;
				issued_q <= 1'b1;
			end
			if (ser.done)
				issued_q <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				if (clear_go)
					rec_cnt_q <= '0;
				else if (wr_cnt)
					rec_cnt_q <= cnt_in;
				if (sweep_go || recall_go) begin
					sweep_done_q  <= 1'b0;
					recall_done_q <= 1'b0;
					lock_err_q    <= 1'b0;
					full_err_q    <= 1'b0;
					no_match_q    <= 1'b0;
				end
				if (sweep_go) begin
					cur_khz_q  <= start_khz_q;
					cur_n_q    <= start_n_q;
					cur_frac_q <= start_frac_q;
					rec_cnt_q  <= '0;
					first_q    <= 1'b1;
					state_q    <= ST_WR_FRAC;
				end else if (recall_go) begin
					scan_q  <= '0;
					found_q <= 1'b0;
					state_q <= ST_FIND;
				end
			end
			ST_WR_FRAC: begin
				if (ser.done)
					state_q <= ST_WR_DIV;
			end
			ST_WR_DIV: begin
				if (ser.done) begin
					wait_q  <= lock_wait_q;
					state_q <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wait_q == '0)
					state_q <= ST_RD_STAT;
				else
					wait_q <= wait_q - WAIT_W'(1);
			end
			ST_RD_STAT: begin
				if (ser.done) begin
					stat_q  <= ser.rdata;
					state_q <= ST_EVAL;
				end
			end
			ST_EVAL: begin
				first_q     <= 1'b0;
				prev_pair_q <= dev_pair;
				if (!dev_lock) begin
					lock_err_q <= 1'b1;
					state_q    <= ST_IDLE;
				end else if (new_pair && rec_full) begin
					full_err_q <= 1'b1;
					state_q    <= ST_IDLE;
				end else begin
					if (new_pair)
						rec_cnt_q <= rec_cnt_q + REC_CNT_W'(1);
					if (at_stop) begin
						sweep_done_q <= 1'b1;
						state_q      <= ST_IDLE;
					end else begin
						cur_khz_q  <= cur_khz_q + delta;
						cur_frac_q <= frac_red[FRAC_W-1:0];
						cur_n_q    <= cur_n_q + N_W'(frac_wrap);
						state_q    <= ST_WR_FRAC;
					end
				end
			end
			ST_FIND: begin
				// records are ascending, so the last one not above wins
				if (scan_ok) begin
					found_q <= 1'b1;
					hit_q   <= scan_q[REC_IDX_W-1:0];
					scan_q  <= scan_q + REC_CNT_W'(1);
				end else if (found_q) begin
					state_q <= ST_WR_CAL;
				end else begin
					no_match_q <= 1'b1;
					state_q    <= ST_IDLE;
				end
			end
			ST_WR_CAL: begin
				if (ser.done)
					state_q <= ST_WR_MFRAC;
			end
			ST_WR_MFRAC: begin
				if (ser.done)
					state_q <= ST_WR_MDIV;
			end
			ST_WR_MDIV: begin
				if (ser.done) begin
					recall_done_q <= 1'b1;
					state_q       <= ST_IDLE;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// read path, data one cycle after the strobe
	// bit 7 left spare so the pair starts on its own byte
	wire [31:0] status_w = (32'(prev_pair_q) << STAT_PAIR_LSB)
		| 32'({stat_q[DEV_LOCK_BIT], no_match_q, full_err_q, lock_err_q,
		recall_done_q, sweep_done_q, !idle});
	wire [31:0] rd_mux =
		reg_addr == OFF_STATUS      ? status_w :
		reg_addr == OFF_START_KHZ   ? 32'(start_khz_q) :
		reg_addr == OFF_STOP_KHZ    ? 32'(stop_khz_q) :
		reg_addr == OFF_STEP_KHZ    ? 32'(step_khz_q) :
		reg_addr == OFF_PFD_KHZ     ? 32'(pfd_khz_q) :
		reg_addr == OFF_START_N     ? 32'(start_n_q) :
		reg_addr == OFF_START_FRAC  ? 32'(start_frac_q) :
		reg_addr == OFF_TARGET_KHZ  ? 32'(target_khz_q) :
		reg_addr == OFF_TARGET_N    ? 32'(target_n_q) :
		reg_addr == OFF_TARGET_FRAC ? 32'(target_frac_q) :
		reg_addr == OFF_LOCK_WAIT   ? 32'(lock_wait_q) :
		reg_addr == OFF_DIV_TMPL    ? 32'(div_tmpl_q) :
		reg_addr == OFF_FRAC_TMPL   ? 32'(frac_tmpl_q) :
		reg_addr == OFF_CAL_TMPL    ? 32'(cal_tmpl_q) :
		reg_addr == OFF_REC_COUNT   ? 32'(rec_cnt_q) :
		reg_addr == OFF_REC_INDEX   ? 32'(rec_idx_q) :
		reg_addr == OFF_REC_DATA    ? 32'(rec_q[rec_idx_q]) : 32'h00000000;

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end
endmodule : vcs_cal_ctrl

// ---- vcs_cal_ctrl_asserts.sv ----
// port checker of the vco calibration controller
`timescale 1ns/1ps
module vcs_cal_ctrl_asserts
	import vcs_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic [4:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        ser_clk,
	input wire logic        ser_csn,
	input wire logic        ser_mosi
);
	logic [7:0] lo_q;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			lo_q <= 8'h00;
		else
			lo_q <= ser_csn ? 8'h00 : lo_q + 8'h01;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence s_head;
		!ser_clk ##1 !ser_clk ##1 ser_clk;
	endsequence
	sequence s_pulse;
		ser_clk [*2] ##1 !ser_clk [*2];
	endsequence
	a_sclk_idle_low: assert property (ser_csn |-> !ser_clk)
		else $error("serial clock high outside a frame");
	a_frame_head: assert property ($fell(ser_csn) |-> s_head)
		else $error("frame start timing off");
	a_sclk_period: assert property ($rose(ser_clk) |-> s_pulse)
		else $error("serial clock period off");
	a_mosi_stable: assert property (ser_clk && $past(ser_clk) |-> $stable(ser_mosi))
		else $error("data moved while serial clock high");
	a_frame_len: assert property ($rose(ser_csn) |-> lo_q == 8'h80)
		else $error("frame not 128 cycles long");
	a_frame_gap: assert property ($rose(ser_csn) |-> ser_csn [*3])
		else $error("frames too close");
	a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (reg_rd && reg_addr > OFF_REC_DATA
		|=> reg_rdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule : vcs_cal_ctrl_asserts

// ---- vcs_cal_ctrl_tb.sv ----
// bench: factory sweep, record readback, field recall, refusals
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
	err_total++; $display("wrong value %s exp %0h seen %0h", n, e, a); end end
module vcs_cal_ctrl_tb
	import vcs_pkg::*;
;
	logic        ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [4:0]  reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
	logic        ser_clk, ser_csn, ser_mosi, lock_detect_out_pin, man;
	logic        lock_ok = 1'b1;
	logic [6:0]  pair;
	int          cal_cnt, err_total = 0, checks_done = 0;
	always #25 ref_clk = ~ref_clk;
	vcs_cal_ctrl dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ser_clk(ser_clk), .ser_csn(ser_csn),
		.ser_mosi(ser_mosi), .lock_detect_out_pin(lock_detect_out_pin));
	vcs_dev_model dev_u (.ser_clk(ser_clk), .ser_csn(ser_csn),
		.ser_mosi(ser_mosi), .lock_ok(lock_ok), .pair_q(pair), .man_q(man),
		.lock_detect_out_pin(lock_detect_out_pin), .cal_cnt(cal_cnt));
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic run(input logic [31:0] cmd, output logic [31:0] s);
		wr(OFF_CTRL, cmd);
		s = 32'h00000001;
		for (int i = 0; i < 3000 && s[0] !== 1'b0; i++)
			rd(OFF_STATUS, s);
		`CHK("idle at end", 1'b0, s[0])
	endtask : run
	task automatic test_sweep;
		logic [31:0] d, e;
		wr(OFF_START_KHZ, 32'h005B8D80);
		wr(OFF_STOP_KHZ, 32'h005BDBA0);
		wr(OFF_STEP_KHZ, 32'h00001B58);
		wr(OFF_PFD_KHZ, 32'h0000C350);
		wr(OFF_START_N, 32'h00000078);
		wr(OFF_LOCK_WAIT, 32'h00000002);
		rd(OFF_STEP_KHZ, d);
		`CHK("step clamp", 32'h00001388, d)
		run(32'h00000001, d);
		`CHK("sweep done", 1'b1, d[1])
		`CHK("last lock", 1'b1, d[6])
		`CHK("last pair", 7'h22, d[14:8])
		`CHK("points", 5, cal_cnt)
		rd(OFF_REC_COUNT, d);
		`CHK("records", 32'h00000003, d)
		wr(OFF_REC_INDEX, 32'h00000000);
		for (int k = 0; k < 3; k++) begin
			rd(OFF_REC_DATA, d);
			e = {1'b0, 2'b01, 5'(k), 24'h5B8D80 + 24'(k * 10000)};
			`CHK("record", e, d)
		end
		$display("sweep test ended");
	endtask : test_sweep
	task automatic test_recall;
		logic [31:0] d;
		int          n;
		n = cal_cnt;
		wr(OFF_TARGET_KHZ, 32'h005BC818);
		wr(OFF_TARGET_N, 32'h00000078);
		wr(OFF_TARGET_FRAC, 32'h00003A98);
		run(32'h00000002, d);
		`CHK("recall done", 1'b1, d[2])
		`CHK("manual enable", 1'b1, man)
		`CHK("manual pair", 7'h21, pair)
		`CHK("div writes", n + 1, cal_cnt)
		$display("recall test ended");
	endtask : test_recall
	task automatic test_nomatch;
		logic [31:0] d;
		int          n;
		n = cal_cnt;
		wr(OFF_TARGET_KHZ, 32'h005B6670);
		run(32'h00000002, d);
		`CHK("no match", 1'b1, d[5])
		`CHK("no write", n, cal_cnt)
		rd(5'h1F, d);
		`CHK("unmapped", 32'h00000000, d)
		$display("no match test ended");
	endtask : test_nomatch
	task automatic test_load;
		logic [31:0] d;
		wr(OFF_CTRL, 32'h00000004);
		rd(OFF_REC_COUNT, d);
		`CHK("cleared", 32'h00000000, d)
		wr(OFF_REC_INDEX, 32'h00000000);
		wr(OFF_REC_DATA, 32'h5A5B8D80);
		wr(OFF_REC_DATA, 32'h5B5BA2F8);
		wr(OFF_REC_COUNT, 32'h00000002);
		wr(OFF_TARGET_KHZ, 32'h005BA2F8);
		run(32'h00000002, d);
		`CHK("own freq", 7'h5B, pair)
		wr(OFF_TARGET_KHZ, 32'h005BA2F7);
		run(32'h00000002, d);
		`CHK("below next", 7'h5A, pair)
		$display("load test ended");
	endtask : test_load
	task automatic test_lockerr;
		logic [31:0] d;
		lock_ok = 1'b0;
		run(32'h00000001, d);
		`CHK("lock error", 1'b1, d[3])
		rd(OFF_REC_COUNT, d);
		`CHK("fresh store", 32'h00000000, d)
		lock_ok = 1'b1;
		$display("lock error test ended");
	endtask : test_lockerr
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		test_sweep();
		test_recall();
		test_nomatch();
		test_load();
		test_lockerr();
		test_done();
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		test_done();
	end
endmodule : vcs_cal_ctrl_tb
bind vcs_cal_ctrl vcs_cal_ctrl_asserts chk_u (.ref_clk(ref_clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.ser_clk(ser_clk), .ser_csn(ser_csn), .ser_mosi(ser_mosi));

// ---- vcs_dev_model.sv ----
// behavioural synthesizer: serial registers, auto and manual vco pick
`timescale 1ns/1ps
module vcs_dev_model
	import vcs_pkg::*;
(
	input  wire logic  ser_clk,
	input  wire logic  ser_csn,
	input  wire logic  ser_mosi,
	input  wire logic  lock_ok,
	output logic       lock_detect_out_pin,
	output logic [6:0] pair_q,
	output logic       man_q,
	output int         cal_cnt
);
	logic [31:0] sh, stat;
	logic [26:0] r1, r6;
	logic        rw;
	int          cnt;
	assign stat = {24'h000000, lock_ok, pair_q};
	initial begin
		{sh, r1, r6, rw, pair_q, man_q, lock_detect_out_pin} = '0;
		cnt = 0;
		cal_cnt = 0;
	end
	always @(posedge ser_clk) begin
		if (!ser_csn) begin
			if (cnt == 0)
				rw = ser_mosi;
			sh = {sh[30:0], ser_mosi};
			cnt++;
		end
	end
	// data leads the sampling edge by half a serial period
	always @(negedge ser_clk) begin
		if (!ser_csn && rw == FRAME_RD && cnt >= 5 && cnt < 32)
			lock_detect_out_pin = stat[31 - cnt];
	end
	always @(posedge ser_csn) begin
		if (cnt == 32 && sh[31] == FRAME_WR) begin
			if (sh[30:27] == DEV_FRAC_ADDR)
				r1 = sh[26:0];
			if (sh[30:27] == DEV_CAL_ADDR)
				r6 = sh[26:0];
			if (sh[30:27] == DEV_DIV_ADDR) begin
				man_q = r1[MAN_CAL_BIT];
				pair_q = man_q ? {r6[22:21], r6[20:16]}
					: {2'b01, 5'(r1[19:0] / 10000)};
				cal_cnt++;
			end
		end
		cnt = 0;
		// released pin must not mimic held data
		lock_detect_out_pin = ~lock_detect_out_pin;
	end
endmodule : vcs_dev_model

// ---- vcs_pkg.sv ----
// constants, register map and state codes of the vco calibration controller
package vcs_pkg;
	// software register map, word index on the plain port
	localparam int          ADDR_W          = 5;
	localparam int          DATA_W          = 32;
	localparam logic [4:0]  OFF_CTRL        = 5'h00;
	localparam logic [4:0]  OFF_STATUS      = 5'h01;
	localparam logic [4:0]  OFF_START_KHZ   = 5'h02;
	localparam logic [4:0]  OFF_STOP_KHZ    = 5'h03;
	localparam logic [4:0]  OFF_STEP_KHZ    = 5'h04;
	localparam logic [4:0]  OFF_PFD_KHZ     = 5'h05;
	localparam logic [4:0]  OFF_START_N     = 5'h06;
	localparam logic [4:0]  OFF_START_FRAC  = 5'h07;
	localparam logic [4:0]  OFF_TARGET_KHZ  = 5'h08;
	localparam logic [4:0]  OFF_TARGET_N    = 5'h09;
	localparam logic [4:0]  OFF_TARGET_FRAC = 5'h0A;
	localparam logic [4:0]  OFF_LOCK_WAIT   = 5'h0B;
	localparam logic [4:0]  OFF_DIV_TMPL    = 5'h0C;
	localparam logic [4:0]  OFF_FRAC_TMPL   = 5'h0D;
	localparam logic [4:0]  OFF_CAL_TMPL    = 5'h0E;
	localparam logic [4:0]  OFF_REC_COUNT   = 5'h0F;
	localparam logic [4:0]  OFF_REC_INDEX   = 5'h10;
	localparam logic [4:0]  OFF_REC_DATA    = 5'h11;
	// control and status bits
	localparam int          CTRL_SWEEP      = 0;
	localparam int          CTRL_RECALL     = 1;
	localparam int          CTRL_CLEAR      = 2;
	localparam int          STAT_PAIR_LSB   = 8;
	// device serial frame: rw, 4-bit address, 27-bit data, msb first
	localparam int          FRAME_W         = 32;
	localparam int          DEV_DATA_W      = 27;
	localparam logic        FRAME_WR        = 1'b0;
	localparam logic        FRAME_RD        = 1'b1;
	localparam logic [3:0]  DEV_DIV_ADDR    = 4'h0;
	localparam logic [3:0]  DEV_FRAC_ADDR   = 4'h1;
	localparam logic [3:0]  DEV_CAL_ADDR    = 4'h6;
	localparam logic [3:0]  DEV_STAT_ADDR   = 4'hA;
	// device field positions
	localparam int          DEV_LOCK_BIT    = 7;
	localparam int          DEV_CORE_LSB    = 5;
	localparam int          DEV_SUB_LSB     = 0;
	localparam int          CORE_W          = 2;
	localparam int          SUB_W           = 5;
	localparam int          PAIR_W          = CORE_W + SUB_W;
	localparam int          MAN_CAL_BIT     = 26;
	localparam int          CAL_SUB_LSB     = 16;
	localparam int          CAL_CORE_LSB    = 21;
	// frequency arithmetic, all frequencies in khz
	localparam int          FREQ_W          = 24;
	localparam int          N_W             = 16;
	localparam int          FRAC_W          = 20;
	localparam logic [23:0] STEP_MAX_KHZ    = 24'h001388;
	localparam logic [23:0] STEP_MIN_KHZ    = 24'h000001;
	// record store: {core, sub, freq}
	localparam int          REC_DEPTH       = 64;
	localparam int          REC_IDX_W       = 6;
	localparam int          REC_CNT_W       = 7;
	localparam int          REC_W           = PAIR_W + FREQ_W;
	// timing
	localparam int          CLK_PERIOD_NS   = 50;
	localparam int          LOCK_TIME_NS    = 100000;
	localparam int          LOCK_CYC        =
		(LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WAIT_W          = 16;
	localparam int          SCLK_HALF_NS    = 100;
	localparam int          SER_HALF        = SCLK_HALF_NS / CLK_PERIOD_NS;
	localparam int          SER_DIV_W       = 4;
	localparam int          SER_CNT_W       = 5;

	typedef enum logic [10:0] {
		ST_IDLE     = 11'h001,
		ST_WR_FRAC  = 11'h002,
		ST_WR_DIV   = 11'h004,
		ST_WAIT     = 11'h008,
		ST_RD_STAT  = 11'h010,
		ST_EVAL     = 11'h020,
		ST_FIND     = 11'h040,
		ST_WR_CAL   = 11'h080,
		ST_WR_MFRAC = 11'h100,
		ST_WR_MDIV  = 11'h200,
		ST_SPARE    = 11'h400
	} vcs_state_t;
endpackage : vcs_pkg

// ---- vcs_ser_if.sv ----
// frame request and answer between the sequencer and the serial shifter
`timescale 1ns/1ps
interface vcs_ser_if;
	logic                  start;
	logic [31:0]           word;
	logic                  busy;
	logic                  done;
	logic [26:0]           rdata;
	modport ctrl  (output start, output word, input busy, input done,
	               input rdata);
	modport shift (input start, input word, output busy, output done,
	               output rdata);
endinterface : vcs_ser_if

// ---- vcs_ser_shift.sv ----
// serial shifter for one 32-bit register frame to the synthesizer
`timescale 1ns/1ps
module vcs_ser_shift
	import vcs_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	vcs_ser_if.shift          req,
	output logic              ser_clk,
	output logic              ser_csn,
	output logic              ser_mosi,
	input  wire logic         ser_miso
);
	logic                     active_q;
	logic                     done_q;
	logic [FRAME_W-1:0]       sh_q;
	logic [DEV_DATA_W-1:0]    rx_q;
	logic [DEV_DATA_W-1:0]    rdata_q;
	logic [SER_DIV_W-1:0]     div_q;
	logic [SER_CNT_W-1:0]     bit_q;
	wire                      half_end = div_q == SER_DIV_W'(SER_HALF - 1);
	wire                      last_bit = bit_q == SER_CNT_W'(FRAME_W - 1);

	assign req.busy  = active_q;
	assign req.done  = done_q;
	assign req.rdata = rdata_q;

	// data changes on the falling edge, read data is taken on the rising one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_q <= 1'b0;
			done_q   <= 1'b0;
			sh_q     <= '0;
			rx_q     <= '0;
			rdata_q  <= '0;
			div_q    <= '0;
			bit_q    <= '0;
			ser_clk  <= 1'b0;
			ser_csn  <= 1'b1;
			ser_mosi <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!active_q) begin
				if (req.start) begin
					active_q <= 1'b1;
					ser_csn  <= 1'b0;
					sh_q     <= req.word;
					ser_mosi <= req.word[FRAME_W-1];
					div_q    <= '0;
					bit_q    <= '0;
				end
			end else if (!half_end) begin
				div_q <= div_q + SER_DIV_W'(1);
			end else begin
				div_q   <= '0;
				ser_clk <= !ser_clk;
				if (!ser_clk) begin
					rx_q <= {rx_q[DEV_DATA_W-2:0], ser_miso};
				end else if (last_bit) begin
					active_q <= 1'b0;
					ser_csn  <= 1'b1;
					done_q   <= 1'b1;
					rdata_q  <= rx_q;
				end else begin
					bit_q    <= bit_q + SER_CNT_W'(1);
					sh_q     <= {sh_q[FRAME_W-2:0], 1'b0};
					ser_mosi <= sh_q[FRAME_W-2];
				end
			end
		end
	end
endmodule : vcs_ser_shift
